// ==== hw/bst_input_module.sv ====
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module bst_input_module #(
  parameter logic [31:0] CPS_RST = 32'd32000000,
  parameter logic [15:0] BAUD_RST = 16'd2170
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stream_clk,
  input wire logic [31:0] input_bit_stream,
  input wire logic second_tick,
  input wire logic input_validity,
  input wire logic alternate_second_tick,
  input wire logic aux_serial_input,
  output logic tx_valid,
  output logic [31:0] tx_data,
  output logic [31:0] tx_second,
  output logic [31:0] tx_subsec,
  output logic tx_on_second,
  output logic tx_validity,
  output logic epoch_monitor_pulse,
  output logic aux_valid,
  output logic [7:0] aux_byte
);

  // Legal active sets hold a power-of-two count of streams
  function automatic logic mask_legal(input logic [31:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < bst_pkg::NSTR; i++)
    begin
      n = n + {5'h00, m[i]};
    end
    return (n != 6'h00) && ((n & (n - 6'h01)) == 6'h00);
  endfunction : mask_legal

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: clock, streams, tick, validity, alt tick, aux line
  logic [bst_pkg::SYN_W-1:0] s1_q, s2_q, s3_q, f_q, f_d;
  logic clk_prev_q;
  // Aux line idles high; resetting it low would fake a start bit
  localparam logic [bst_pkg::SYN_W-1:0] SYN_IDLE = {1'b1, {(bst_pkg::SYN_W-1){1'b0}}};
  wire [bst_pkg::SYN_W-1:0] raw_in = {aux_serial_input, alternate_second_tick,
    input_validity, second_tick, stream_clk, input_bit_stream};
  // Change accepted only when stages two and three agree
  assign f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= SYN_IDLE;
      s2_q <= SYN_IDLE;
      s3_q <= SYN_IDLE;
      f_q <= SYN_IDLE;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
      clk_prev_q <= f_q[32];
    end
  end

  wire [31:0] str_in = f_q[31:0]; // [RULE20]
  wire s_clk = f_q[32];
  wire s_tick = f_q[33];
  wire s_valid = f_q[34];
  wire s_alt = f_q[35];
  wire s_rx = f_q[36];
  logic alt_prev_q;
  // Streams, tick and validity all taken on this one edge
  wire str_edge = s_clk & ~clk_prev_q; // [RULE24] [RULE5]
  wire alt_rise = s_alt & ~alt_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control and status registers
  logic [31:0] ctrl_q, mask_q, setsec_q, cps_q, repval_q;
  logic [15:0] baud_q;
  logic arm_q, tval_q, tick_seen_q, rep_req_q, rep_rdy_q, ovf_q;
  logic [31:0] sec_q, sub_q;
  logic [11:0] auxcnt_q;
  wire tx_en = ctrl_q[bst_pkg::C_TXEN];
  wire alt_sel = ctrl_q[bst_pkg::C_ALT]; // [RULE14]
  wire [2:0] rate_raw = ctrl_q[bst_pkg::C_RATE_LO +: bst_pkg::C_RATE_W];
  // Codes above the top ratio clamp; 64/128 MHz clocks need the big ratios
  wire [2:0] rate = (rate_raw > bst_pkg::RATE_MAX) ? bst_pkg::RATE_MAX : rate_raw; // [RULE4]
  wire mask_ok = mask_legal(mask_q); // [RULE2]

  wire wr_acc = psel & penable & pwrite & pready;
  wire rd_setup = psel & ~penable;
  wire w_ctrl = wr_acc & (paddr == bst_pkg::OFS_CTRL);
  wire w_mask = wr_acc & (paddr == bst_pkg::OFS_MASK);
  wire w_set = wr_acc & (paddr == bst_pkg::OFS_SETSEC);
  wire w_cps = wr_acc & (paddr == bst_pkg::OFS_CPS);
  wire w_stat = wr_acc & (paddr == bst_pkg::OFS_STAT);
  wire w_rep = wr_acc & (paddr == bst_pkg::OFS_REPREQ);
  wire w_baud = wr_acc & (paddr == bst_pkg::OFS_BAUD);

  ////////////////////////////////////////////////////////////////////////////
  // Observe-time counter and sampling
  logic [bst_pkg::PH_W-1:0] ph_q;
  wire prim_load = str_edge & s_tick & arm_q & ~alt_sel; // [RULE22]
  wire alt_load = alt_rise & arm_q & alt_sel; // [RULE14]
  wire tick_evt = (str_edge & s_tick & ~alt_sel) | (alt_rise & alt_sel); // [RULE11]
  // Tag for the bit taken on this edge: one tag for every stream
  wire [31:0] tag_sec = prim_load ? setsec_q : sec_q; // [RULE16]
  wire [31:0] tag_sub = prim_load ? 32'h0 : sub_q;
  wire [31:0] sub_inc = tag_sub + 32'h1;
  wire sub_wrap = (sub_inc >= cps_q);
  wire [bst_pkg::PH_W-1:0] rate_mask = ~({bst_pkg::PH_W{1'b1}} << rate);
  // Decimated sample; a load restarts the phase so the tick bit is taken
  wire take = str_edge & (prim_load | ((ph_q & rate_mask) == '0)); // [RULE1] [RULE18]
  wire epoch_d = str_edge & (tval_q | prim_load) & (tag_sub == 32'h0); // [RULE15]

  // Counter keeps time only by stream clock cycles once set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_q <= '0;
      sub_q <= '0;
      ph_q <= '0;
      tval_q <= 1'b0;
      arm_q <= 1'b0;
      alt_prev_q <= 1'b0;
    end
    else
    begin
      alt_prev_q <= s_alt;
      if (alt_load)
      begin
        sec_q <= setsec_q; // [RULE21]
        sub_q <= '0;
      end
      else if (str_edge)
      begin
        sec_q <= sub_wrap ? tag_sec + 32'h1 : tag_sec; // [RULE21]
        sub_q <= sub_wrap ? 32'h0 : sub_inc;
      end
      if (prim_load)
        ph_q <= {{(bst_pkg::PH_W-1){1'b0}}, 1'b1};
      else if (alt_load)
        ph_q <= '0;
      else if (str_edge)
        ph_q <= ph_q + 1'b1;
      if (prim_load | alt_load)
        tval_q <= 1'b1;
      // Load wins over a fresh arm in the same cycle; later ticks ignored
      if (prim_load | alt_load)
        arm_q <= 1'b0; // [RULE22]
      else if (w_set)
        arm_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transport output: active streams, common tag, tick mark, validity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_second <= '0;
      tx_subsec <= '0;
      tx_on_second <= 1'b0;
      tx_validity <= 1'b0;
      epoch_monitor_pulse <= 1'b0;
    end
    else
    begin
      tx_valid <= take & tx_en; // [RULE19]
      epoch_monitor_pulse <= epoch_d; // [RULE15]
      if (take)
      begin
        tx_data <= str_in & mask_q; // [RULE3]
        tx_second <= tag_sec; // [RULE17]
        tx_subsec <= tag_sub; // [RULE17]
        tx_on_second <= s_tick; // [RULE6]
        tx_validity <= s_valid; // [RULE8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Aux serial receiver, 8 data bits, one stop bit
  bst_pkg::bst_rx_e rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  wire rx_tick = (rx_cnt_q == 16'h0);
  wire [15:0] half_baud = {1'b0, baud_q[15:1]};
  wire aux_done = (rx_st_q == bst_pkg::BST_STOP) & rx_tick & s_rx;
  wire aux_cnt_clr = str_edge & s_tick; // Per-second byte count clears on each primary tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q <= bst_pkg::BST_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      aux_valid <= 1'b0;
      aux_byte <= '0;
      auxcnt_q <= '0;
    end
    else
    begin
      rx_cnt_q <= rx_tick ? baud_q : rx_cnt_q - 16'h1;
      aux_valid <= aux_done; // [RULE9]
      if (aux_done)
        aux_byte <= rx_sh_q;
      // Counter saturates; overflow is flagged separately
      if (aux_cnt_clr)
        auxcnt_q <= '0;
      else if (aux_done && auxcnt_q != bst_pkg::AUX_MAX)
        auxcnt_q <= auxcnt_q + 12'h1; // [RULE9]
      case (rx_st_q)
        bst_pkg::BST_IDLE:
          if (!s_rx)
          begin
            rx_st_q <= bst_pkg::BST_START;
            rx_cnt_q <= half_baud;
          end
        bst_pkg::BST_START:
          if (rx_tick)
            rx_st_q <= s_rx ? bst_pkg::BST_IDLE : bst_pkg::BST_DATA;
        bst_pkg::BST_DATA:
          if (rx_tick)
          begin
            rx_sh_q <= {s_rx, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= bst_pkg::BST_STOP;
          end
        bst_pkg::BST_STOP:
          if (rx_tick)
            rx_st_q <= bst_pkg::BST_IDLE;
        default:
          rx_st_q <= bst_pkg::BST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; hardware set beats software clear on sticky flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= bst_pkg::CTRL_RST;
      mask_q <= bst_pkg::MASK_RST;
      setsec_q <= '0;
      cps_q <= CPS_RST;
      baud_q <= BAUD_RST;
      tick_seen_q <= 1'b0;
      rep_req_q <= 1'b0;
      rep_rdy_q <= 1'b0;
      repval_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (w_ctrl)
        ctrl_q <= pwdata;
      if (w_mask)
        mask_q <= pwdata;
      if (w_set)
        setsec_q <= pwdata;
      if (w_cps)
        cps_q <= pwdata;
      if (w_baud)
        baud_q <= pwdata[15:0];
      if (tick_evt)
        tick_seen_q <= 1'b1; // [RULE11]
      else if (w_stat && pwdata[bst_pkg::S_TICK])
        tick_seen_q <= 1'b0;
      if (aux_done && auxcnt_q == bst_pkg::AUX_MAX)
        ovf_q <= 1'b1;
      else if (w_stat && pwdata[bst_pkg::S_OVF])
        ovf_q <= 1'b0;
      // Report the counter at the next epoch pulse after the request
      if (epoch_d && rep_req_q)
      begin
        repval_q <= tag_sec; // [RULE23] [RULE12]
        rep_rdy_q <= 1'b1;
        rep_req_q <= 1'b0;
      end
      else if (w_rep)
      begin
        rep_req_q <= 1'b1;
        rep_rdy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; registered in the setup cycle so prdata comes straight from a flop with no wait state
  wire [31:0] stat_w = {25'h0, rep_req_q, ovf_q, rep_rdy_q, mask_ok,
    tick_seen_q, tval_q, arm_q}; // [RULE10] [RULE13]
  wire hit = (paddr == bst_pkg::OFS_CTRL) | (paddr == bst_pkg::OFS_MASK) |
    (paddr == bst_pkg::OFS_SETSEC) | (paddr == bst_pkg::OFS_CPS) |
    (paddr == bst_pkg::OFS_SEC) | (paddr == bst_pkg::OFS_SUB) |
    (paddr == bst_pkg::OFS_STAT) | (paddr == bst_pkg::OFS_REPREQ) |
    (paddr == bst_pkg::OFS_REPVAL) | (paddr == bst_pkg::OFS_AUXCNT) |
    (paddr == bst_pkg::OFS_BAUD);
  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr)
      bst_pkg::OFS_CTRL: rd_mux = ctrl_q;
      bst_pkg::OFS_MASK: rd_mux = mask_q;
      bst_pkg::OFS_SETSEC: rd_mux = setsec_q;
      bst_pkg::OFS_CPS: rd_mux = cps_q;
      bst_pkg::OFS_SEC: rd_mux = sec_q;
      bst_pkg::OFS_SUB: rd_mux = sub_q;
      bst_pkg::OFS_STAT: rd_mux = stat_w;
      bst_pkg::OFS_REPVAL: rd_mux = repval_q;
      bst_pkg::OFS_AUXCNT: rd_mux = {20'h0, auxcnt_q};
      bst_pkg::OFS_BAUD: rd_mux = {16'h0, baud_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_setup;
      if (rd_setup)
      begin
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_inactive;
    tx_valid |-> ((tx_data & ~$past(mask_q)) == 32'h0);
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive stream carried"); // [RULE3]

  property p_load;
    prim_load |=> (tx_second == $past(setsec_q)) && (tx_subsec == 32'h0) && tx_on_second;
  endproperty
  a_load: assert property (p_load) else $error("tick load tag wrong"); // [RULE22]

  property p_disarm;
    (prim_load || alt_load) |=> !arm_q;
  endproperty
  a_disarm: assert property (p_disarm) else $error("set stays armed"); // [RULE22]

  property p_ignore;
    (str_edge && s_tick && !arm_q && !alt_load) |=> (sec_q == $past(sub_wrap) + $past(sec_q));
  endproperty
  a_ignore: assert property (p_ignore) else $error("tick moved counter"); // [RULE21]

  property p_epoch;
    epoch_monitor_pulse |-> (tx_subsec == 32'h0 || !$past(take)) ##1 !epoch_monitor_pulse;
  endproperty
  a_epoch: assert property (p_epoch) else $error("epoch pulse off second"); // [RULE15]

  property p_report;
    (epoch_d && rep_req_q) |=> rep_rdy_q && (repval_q == $past(tag_sec));
  endproperty
  a_report: assert property (p_report) else $error("report not captured"); // [RULE23]

  property p_rate;
    tx_valid |-> $past(str_edge) && $past(tx_en);
  endproperty
  a_rate: assert property (p_rate) else $error("sample off stream edge"); // [RULE1]

  property p_validity;
    tx_valid |-> (tx_validity == $past(s_valid));
  endproperty
  a_validity: assert property (p_validity) else $error("validity not carried"); // [RULE8]

  property p_tick;
    tick_evt |=> tick_seen_q [*2] or (tick_seen_q ##1 1'b1);
  endproperty
  a_tick: assert property (p_tick) else $error("tick not flagged"); // [RULE11]

  property p_apb;
    pready |=> !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("pready held"); // [RULE10]

  c_load: cover property (prim_load ##[1:300] epoch_monitor_pulse);
  c_alt: cover property (alt_load);
  c_report: cover property (w_rep ##[1:1000] rep_rdy_q);
  c_aux: cover property (aux_valid);

endmodule : bst_input_module
`default_nettype wire

// ==== common/bst_pkg.sv ====
// Summary of operation
// [RULE1] Sample streams at one selectable common rate
// [RULE2] Active set is 1,2,4,8,16 or 32; the code still applies any other mask and only flags it in mask_ok
// [RULE3] Inactive streams neither sampled nor carried
// [RULE4] Optional 64 and 128 MHz clock rates
// [RULE5] Stream clock is reference, at least rate
// [RULE6] Tick-marked bits are tagged on integer second
// [RULE7] Sender asserts tick with on-second bit
// [RULE8] Validity input carried onward uninterpreted
// [RULE9] Aux serial bytes, at most 2048 per second
// [RULE10] Two-way control path configures and monitors
// [RULE11] Control side sees second ticks for timing
// [RULE12] Messages leave between two adjacent ticks
// [RULE13] One control path may serve both modules
// [RULE14] Alternate, asynchronous tick replaces primary tick
// [RULE15] Epoch monitor pulse on each counter second
// [RULE16] One common tag for all streams
// [RULE17] Carried time recovers every bit's time
// [RULE18] All streams share one information rate
// [RULE19] Common clock and tick, stamp, send on
// [RULE20] Full feature set gives full compliance level
// [RULE21] Counter loads on tick, then counts cycles
// [RULE22] Set command acts on next tick
// [RULE23] Report counter value at next epoch pulse
// [RULE24] All inputs captured on same clock edge
package bst_pkg;
  localparam int NSTR = 32;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_SETSEC = 8'h08;
  localparam logic [7:0] OFS_CPS = 8'h0C;
  localparam logic [7:0] OFS_SEC = 8'h10;
  localparam logic [7:0] OFS_SUB = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_REPREQ = 8'h1C;
  localparam logic [7:0] OFS_REPVAL = 8'h20;
  localparam logic [7:0] OFS_AUXCNT = 8'h24;
  localparam logic [7:0] OFS_BAUD = 8'h28;
  // Control fields
  localparam int C_TXEN = 0;
  localparam int C_ALT = 1;
  localparam int C_RATE_LO = 4;
  localparam int C_RATE_W = 3;
  localparam logic [2:0] RATE_MAX = 3'h6;
  // Status fields
  localparam int S_ARM = 0;
  localparam int S_TVAL = 1;
  localparam int S_TICK = 2;
  localparam int S_MOK = 3;
  localparam int S_REP = 4;
  localparam int S_OVF = 5;
  localparam int S_REQ = 6;
  // Reset values
  localparam logic [31:0] MASK_RST = 32'hFFFFFFFF;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  // Aux byte limit per second
  localparam logic [11:0] AUX_MAX = 12'h800;
  localparam int PH_W = 7;
  localparam int SYN_W = NSTR + 5;
  typedef enum logic [1:0] {BST_IDLE, BST_START, BST_DATA, BST_STOP} bst_rx_e;
endpackage : bst_pkg

// ==== verification/bst_acq_model.sv ====
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Acquisition side: free-running stream clock, data, tick, validity, aux line
module bst_acq_model #(
  parameter int TICK_EVERY = 15,
  parameter int BAUD = 7
) (
  input wire logic pclk,
  output logic stream_clk,
  output logic [31:0] input_bit_stream,
  output logic second_tick,
  output logic input_validity,
  output logic alternate_second_tick,
  output logic aux_serial_input
);
  int edge_n;
  // Stream clock runs free, phase offset from pclk on purpose
  initial
  begin
    stream_clk = 1'b0;
    input_bit_stream = 32'h1234ABCD;
    second_tick = 1'b0;
    input_validity = 1'b0;
    alternate_second_tick = 1'b0;
    aux_serial_input = 1'b1;
    edge_n = 0;
    #1.3;
    forever #24 stream_clk = ~stream_clk;
  end
  // Change on falling edge so data, tick and validity are stable across the sampling rise
  always @(negedge stream_clk)
  begin
    input_bit_stream <= {input_bit_stream[30:0],
      input_bit_stream[31] ^ input_bit_stream[21] ^ input_bit_stream[1] ^ input_bit_stream[0]};
    input_validity <= ~input_validity ^ input_bit_stream[5];
    second_tick <= (edge_n % TICK_EVERY) == 0;
    edge_n <= edge_n + 1;
  end
  // Alternate tick, unrelated to the stream clock
  task automatic alt_pulse();
    alternate_second_tick <= 1'b1;
    repeat (4) @(posedge pclk);
    alternate_second_tick <= 1'b0;
  endtask : alt_pulse
  // One 8N1 character, LSB first; the caller keeps the per-second count low
  task automatic send_aux(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      aux_serial_input <= f[i];
      repeat (BAUD + 1) @(posedge pclk);
    end
  endtask : send_aux
endmodule : bst_acq_model
`default_nettype wire

// ==== verification/bit_stream_input_timetag_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module bit_stream_input_timetag_bench;
  localparam int CPS = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, aux_byte;
  logic [31:0] pwdata, prdata, tx_data, tx_second, tx_subsec, input_bit_stream;
  logic tx_valid, tx_on_second, tx_validity, epoch_monitor_pulse, aux_valid;
  logic stream_clk, second_tick, input_validity, alternate_second_tick, aux_serial_input;
  logic [31:0] m_mask, s_data, rd, setsec, rep_exp, mk;
  logic s_tick, s_val;
  int bad_count, samples_checked, cyc, pulses, m_sec, m_sub, cnt;
  bit m_set, m_arm, alt_pend, req_on;
  logic [7:0] aux_q[$];
  logic [31:0] mt[8] = '{32'h1, 32'h3, 32'hF, 32'hFF, 32'hFFFF, 32'hFFFFFFFF, 32'h7, 32'h0};

  bst_input_module #(.CPS_RST(32'h14), .BAUD_RST(16'h7)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stream_clk(stream_clk),
    .input_bit_stream(input_bit_stream), .second_tick(second_tick),
    .input_validity(input_validity), .alternate_second_tick(alternate_second_tick),
    .aux_serial_input(aux_serial_input), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_second(tx_second), .tx_subsec(tx_subsec), .tx_on_second(tx_on_second),
    .tx_validity(tx_validity), .epoch_monitor_pulse(epoch_monitor_pulse),
    .aux_valid(aux_valid), .aux_byte(aux_byte));
  // Ticks every 15 edges, off the 20-cycle second, so late ticks must be ignored
  bst_acq_model #(.TICK_EVERY(15), .BAUD(7)) acq (.pclk(pclk), .stream_clk(stream_clk),
    .input_bit_stream(input_bit_stream), .second_tick(second_tick),
    .input_validity(input_validity), .alternate_second_tick(alternate_second_tick),
    .aux_serial_input(aux_serial_input));

  // 250 MHz system clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // APB transfer; hangs are caught by the cycle ceiling
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Writes land mid stream period so no sample straddles the change
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge stream_clk);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdchk
  ////////////////////////////////////////////////////////////////////////////////
  // Reference model: sample and tag of each stream edge
  always @(posedge stream_clk)
  begin
    s_data = input_bit_stream;
    s_tick = second_tick;
    s_val = input_validity;
    if (alt_pend || (m_arm && second_tick))
    begin
      m_sec = setsec;
      m_sub = 0;
      m_arm = 0;
      alt_pend = 0;
      m_set = 1;
    end
    else if (m_set)
    begin
      m_sub++;
      if (m_sub == CPS)
      begin
        m_sub = 0;
        m_sec++;
      end
    end
  end
  // Compare outputs half a cycle after they launch; also the cycle ceiling
  always @(negedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
    if (aux_valid === 1'b1)
      chk("aux_byte", aux_q.pop_front(), aux_byte);
    if (tx_valid === 1'b1)
    begin
      pulses++;
      chk("tx_data", s_data & m_mask, tx_data);
      chk("tx_on_second", s_tick, tx_on_second);
      chk("tx_validity", s_val, tx_validity);
      chk("epoch", m_set && m_sub == 0, epoch_monitor_pulse);
      if (m_set)
      begin
        chk("tx_second", m_sec, tx_second);
        chk("tx_subsec", m_sub, tx_subsec);
      end
      if (epoch_monitor_pulse === 1'b1 && req_on)
      begin
        rep_exp = m_sec;
        req_on = 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    m_mask = bst_pkg::MASK_RST;
    void'($urandom(32'h5C448967));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl", bst_pkg::OFS_CTRL, 32'hFFFFFFFF, bst_pkg::CTRL_RST);
    rdchk("mask", bst_pkg::OFS_MASK, 32'hFFFFFFFF, bst_pkg::MASK_RST);
    rdchk("cps", bst_pkg::OFS_CPS, 32'hFFFFFFFF, CPS);
    rdchk("baud", bst_pkg::OFS_BAUD, 32'hFFFF, 32'h7);
    rdchk("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
    chk("unmapped err", 1'b1, er);
    $display("test reset done");
    // Primary tick sets the counter on the next tick only
    wr(bst_pkg::OFS_CTRL, 32'h1);
    setsec = $urandom & 32'hFFFF;
    wr(bst_pkg::OFS_SETSEC, setsec);
    m_arm = 1;
    repeat (50) @(posedge stream_clk);
    rdchk("status set", bst_pkg::OFS_STAT, 32'h3, 32'h2);
    $display("test primary set done");
    // Active sets: tabled and random masks
    for (int i = 0; i < 10; i++)
    begin
      mk = (i < 8) ? mt[i] : $urandom;
      wr(bst_pkg::OFS_MASK, mk);
      m_mask = mk;
      cnt = $countones(mk);
      repeat (3) @(posedge stream_clk);
      rdchk("mask legal", bst_pkg::OFS_STAT, 32'h8,
        ((cnt & (cnt - 1)) == 0 && cnt != 0) ? 32'h8 : 32'h0);
    end
    $display("test masks done");
    // Every rate code, the clamped one, then transmit off, over 64 edges
    for (int r = 0; r < 9; r++)
    begin
      wr(bst_pkg::OFS_CTRL, ((r < 8) ? 32'h1 : 32'h0) | ((r & 7) << bst_pkg::C_RATE_LO));
      @(posedge stream_clk);
      pulses = 0;
      repeat (64) @(posedge stream_clk);
      chk("rate pulses", (r < 8) ? (64 >> ((r > bst_pkg::RATE_MAX) ? bst_pkg::RATE_MAX : r)) : 0,
        pulses);
    end
    wr(bst_pkg::OFS_CTRL, 32'h1);
    $display("test rates done");
    // Report at next epoch pulse; tick-seen flag after clearing
    apb(1'b1, bst_pkg::OFS_REPREQ, 32'h1);
    req_on = 1;
    apb(1'b1, bst_pkg::OFS_STAT, 32'h4);
    repeat (30) @(posedge stream_clk);
    rdchk("report ready", bst_pkg::OFS_STAT, 32'h14, 32'h14);
    rdchk("report value", bst_pkg::OFS_REPVAL, 32'hFFFFFFFF, rep_exp);
    $display("test report done");
    // Alternate tick sets once; a second one unarmed is ignored
    wr(bst_pkg::OFS_CTRL, 32'h3);
    setsec = $urandom & 32'hFFFF;
    wr(bst_pkg::OFS_SETSEC, setsec);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge stream_clk);
      @(posedge pclk);
      alt_pend = (k == 0);
      acq.alt_pulse();
      repeat (25) @(posedge stream_clk);
    end
    $display("test alternate done");
    // Aux characters
    for (int j = 0; j < 4; j++)
    begin
      mk = $urandom;
      aux_q.push_back(mk[7:0]);
      acq.send_aux(mk[7:0]);
    end
    repeat (20) @(posedge pclk);
    chk("aux left", 0, aux_q.size());
    rdchk("aux ovf", bst_pkg::OFS_STAT, 32'h20, 32'h0);
    $display("test aux done");
    results();
  end
endmodule : bit_stream_input_timetag_bench
`default_nettype wire
